/* design/flash_block_lock.sv */
// Primary block lock register with APB slave and sector protection
//
// Function
// RULE1 - Lock is OR of primary and secondary
// RULE2 - Password write sets write-enable until reset
// RULE3 - Write-enable bit cannot be written directly
// RULE4 - Lock fields ignore writes while write-enable clear
// RULE5 - Interlock blocks lock writes until done
// RULE6 - Suspended operation blocks lock writes
// RULE7 - Test lock guards program; test erase refused
// RULE8 - Mid and low lock bits guard sectors
// RULE9 - Mid bits zero, one map sectors six, seven
// RULE10 - Low bits five to zero map sectors
// RULE11 - Low bits fifteen to six read one
// RULE12 - Absent sectors stay locked, ignore writes
// RULE13 - Reset reloads locks from nonvolatile image
// RULE14 - Upper image word ignored when loading
// RULE15 - Erased image loads every lock set
// RULE16 - Locked request leaves data, reports good
// RULE17 - Wrong password changes nothing
`timescale 1ns/1ps
module flash_block_lock
  import flash_lock_pkg::*;
(
  // Clock and reset
  input  wire  logic                     clock,
  input  wire  logic                     rstn,
  // APB slave
  input  wire  flash_lock_pkg::apb_req_t apbReq,
  output flash_lock_pkg::apb_rsp_t       apbRsp,
  // Nonvolatile image read
  output logic                           nvReadReq,
  input  wire  logic                     nvReadValid,
  input  wire  logic [63:0]              nvImage,
  // Secondary lock state
  input  wire  flash_lock_pkg::lock_t    secondaryLock,
  // Module control status
  input  wire  logic                     interlockWrite,
  input  wire  logic                     controlDone,
  input  wire  logic                     hvSuspended,
  // Program and erase request
  input  wire  flash_lock_pkg::op_req_t  opReq,
  output flash_lock_pkg::op_rsp_t        opRsp,
  // Final lock state
  output flash_lock_pkg::lock_t          effectiveLock
);

  import flash_lock_pkg::*;

  lock_state_t s_q;
  lock_state_t s_d;
  logic        allow;
  logic        accessDone;
  logic        lockWritable;
  logic [7:0]  addr;

  function automatic lock_t fit_lock(input logic [31:0] word);
    lock_t l;
    l.test = word[TEST_BIT];
    l.mid  = word[MID_LSB +: 2] | ~MID_PRESENT;  // see RULE12
    l.low  = word[LOW_LSB +: 16] | ~LOW_PRESENT;  // see RULE11 see RULE12
    return l;
  endfunction : fit_lock

  function automatic logic [31:0] lock_word(input logic we, input lock_t l);
    logic [31:0] w;
    w = 32'h00000000;
    w[WE_BIT] = we;
    w[TEST_BIT] = l.test;
    w[MID_LSB +: 2] = l.mid;
    w[LOW_LSB +: 16] = l.low;
    return w;
  endfunction : lock_word

  flash_lock_guard u_guard (
    .effective (s_q.effective),
    .opReq     (opReq),
    .allow     (allow)
  );

  assign addr       = apbReq.paddr;

  always_comb
  begin
    s_d = s_q;
    accessDone = apbReq.psel & apbReq.penable & s_q.apb.pready;
    lockWritable = s_q.writeEnable & ~s_q.pending & ~hvSuspended & ~interlockWrite;  // see RULE4 see RULE5 see RULE6

    // Image load after reset release
    case (s_q.phase)
      PHASE_REQ:
      begin
        s_d.nvReadReq = 1'b1;
        s_d.phase = PHASE_WAIT;
      end
      PHASE_WAIT:
      begin
        if (nvReadValid)
        begin
          s_d.nvReadReq = 1'b0;
          s_d.image = nvImage;
          s_d.primary = fit_lock(nvImage[31:0]);  // see RULE13 see RULE14 see RULE15
          s_d.phase = PHASE_READY;
        end
      end
      PHASE_READY:
      begin
        s_d.nvReadReq = 1'b0;
      end
      default:
      begin
        s_d.phase = PHASE_REQ;
      end
    endcase

    // Interlock pending; a new interlock wins over done
    if (interlockWrite)
    begin
      s_d.pending = 1'b1;  // see RULE5
    end
    else if (controlDone)
    begin
      s_d.pending = 1'b0;  // see RULE5
    end

    // Register writes at the completing access edge
    if (accessDone && apbReq.pwrite && addr == PRIMARY_OFF)
    begin
      if (apbReq.pwdata == LOCK_PASSWORD)
      begin
        s_d.writeEnable = 1'b1;  // see RULE2
      end
      else if (lockWritable)
      begin
        s_d.primary = fit_lock(apbReq.pwdata);  // see RULE3 see RULE4
      end
      else
      begin
        s_d.primary = s_q.primary;  // see RULE17
      end
    end

    // APB answer, one wait-free access once loaded
    s_d.apb.pready = apbReq.psel & (s_q.phase == PHASE_READY) & ~accessDone;
    s_d.apb.pslverr = 1'b0;
    s_d.apb.prdata = 32'h00000000;
    if (apbReq.psel && !accessDone)
    begin
      case (addr)
        PRIMARY_OFF:
        begin
          s_d.apb.prdata = lock_word(s_q.writeEnable, s_q.primary);
        end
        IMAGE_LO_OFF:
        begin
          s_d.apb.prdata = s_q.image[31:0];
        end
        IMAGE_HI_OFF:
        begin
          s_d.apb.prdata = s_q.image[63:32];
        end
        STATUS_OFF:
        begin
          s_d.apb.prdata = lock_word(1'b0, s_q.effective);
          s_d.apb.prdata[ST_PENDING_BIT] = s_q.pending;
          s_d.apb.prdata[ST_SUSP_BIT] = hvSuspended;
          s_d.apb.prdata[ST_READY_BIT] = (s_q.phase == PHASE_READY);
        end
        default:
        begin
          s_d.apb.pslverr = 1'b1;
        end
      endcase
    end

    // Final lock state
    s_d.effective = s_q.primary | secondaryLock;  // see RULE1

    // Program and erase verdict
    s_d.op.done = opReq.valid;
    s_d.op.execute = opReq.valid & allow;  // see RULE7 see RULE8
    s_d.op.lockedGood = opReq.valid & ~allow;  // see RULE16
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q.phase       <= PHASE_REQ;
      s_q.writeEnable <= 1'b0;
      s_q.primary     <= LOCK_RESET;
      s_q.pending     <= 1'b0;
      s_q.image       <= IMAGE_RESET;
      s_q.apb         <= APB_RSP_RESET;
      s_q.nvReadReq   <= 1'b0;
      s_q.effective   <= LOCK_RESET;
      s_q.op          <= OP_RSP_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign apbRsp        = s_q.apb;
  assign nvReadReq     = s_q.nvReadReq;
  assign opRsp         = s_q.op;
  assign effectiveLock = s_q.effective;

endmodule : flash_block_lock

/* design/flash_lock_pkg.sv */
// Constants and carrier types for the flash block lock register
package flash_lock_pkg;

  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 32;
  localparam int          IMAGE_W        = 64;

  // Register byte offsets
  localparam logic [7:0]  PRIMARY_OFF    = 8'h00;
  localparam logic [7:0]  IMAGE_LO_OFF   = 8'h04;
  localparam logic [7:0]  IMAGE_HI_OFF   = 8'h08;
  localparam logic [7:0]  STATUS_OFF     = 8'h0C;

  // Field positions in the primary lock word
  localparam int          WE_BIT         = 31;
  localparam int          TEST_BIT       = 20;
  localparam int          MID_LSB        = 16;
  localparam int          LOW_LSB        = 0;

  // Field positions in the status word
  localparam int          ST_PENDING_BIT = 31;
  localparam int          ST_SUSP_BIT    = 30;
  localparam int          ST_READY_BIT   = 29;

  // Unlock password
  localparam logic [31:0] LOCK_PASSWORD  = 32'hA1A11111;

  // Sectors present in this memory
  localparam logic [1:0]  MID_PRESENT    = 2'h3;
  localparam logic [15:0] LOW_PRESENT    = 16'h003F;

  // Sector codes of a program or erase request
  localparam logic [3:0]  SECTOR_MID0    = 4'h6;
  localparam logic [3:0]  SECTOR_TEST    = 4'h8;

  // Values after reset
  localparam logic [63:0] IMAGE_RESET    = 64'hFFFFFFFFFFFFFFFF;

  typedef struct packed {
    logic        test;
    logic [1:0]  mid;
    logic [15:0] low;
  } lock_t;

  localparam lock_t       LOCK_RESET     = '{test: 1'b1, mid: 2'h3, low: 16'hFFFF};

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic              pready;
    logic [DATA_W-1:0] prdata;
    logic              pslverr;
  } apb_rsp_t;

  localparam apb_rsp_t    APB_RSP_RESET  = '{pready: 1'b0, prdata: 32'h00000000, pslverr: 1'b0};

  typedef struct packed {
    logic       valid;
    logic       erase;
    logic [3:0] sector;
  } op_req_t;

  typedef struct packed {
    logic done;
    logic execute;
    logic lockedGood;
  } op_rsp_t;

  localparam op_rsp_t     OP_RSP_RESET   = '{done: 1'b0, execute: 1'b0, lockedGood: 1'b0};

  typedef enum logic [1:0] {
    PHASE_REQ,
    PHASE_WAIT,
    PHASE_READY
  } phase_t;

  typedef struct packed {
    phase_t         phase;
    logic           writeEnable;
    lock_t          primary;
    logic           pending;
    logic [63:0]    image;
    apb_rsp_t       apb;
    logic           nvReadReq;
    lock_t          effective;
    op_rsp_t        op;
  } lock_state_t;

endpackage : flash_lock_pkg

/* design/flash_lock_guard.sv */
// Sector protection check for one program or erase request
`timescale 1ns/1ps
module flash_lock_guard
  import flash_lock_pkg::*;
(
  // Final lock state
  input  wire flash_lock_pkg::lock_t   effective,
  // Request
  input  wire flash_lock_pkg::op_req_t opReq,
  // Verdict
  output logic                         allow
);

  import flash_lock_pkg::*;

  always_comb
  begin
    allow = 1'b0;
    if (opReq.sector < SECTOR_MID0)
    begin
      allow = ~effective.low[opReq.sector];  // see RULE8 see RULE10
    end
    else if (opReq.sector < SECTOR_TEST)
    begin
      allow = ~effective.mid[opReq.sector[0]];  // see RULE8 see RULE9
    end
    else if (opReq.sector == SECTOR_TEST)
    begin
      allow = ~effective.test & ~opReq.erase;  // see RULE7
    end
    else
    begin
      allow = 1'b0;
    end
  end

endmodule : flash_lock_guard

/* dv/flash_block_lock_chk.sv */
// Port assertions for the flash block lock register
`timescale 1ns/1ps
module flash_block_lock_chk
  import flash_lock_pkg::*;
(
  // Clock and reset
  input wire logic                     clock,
  input wire logic                     rstn,
  // Ports watched
  input wire flash_lock_pkg::apb_req_t apbReq,
  input wire flash_lock_pkg::apb_rsp_t apbRsp,
  input wire logic                     nvReadReq,
  input wire logic                     nvReadValid,
  input wire logic [63:0]              nvImage,
  input wire flash_lock_pkg::lock_t    secondaryLock,
  input wire logic                     interlockWrite,
  input wire logic                     controlDone,
  input wire logic                     hvSuspended,
  input wire flash_lock_pkg::op_req_t  opReq,
  input wire flash_lock_pkg::op_rsp_t  opRsp,
  input wire flash_lock_pkg::lock_t    effectiveLock
);
  import flash_lock_pkg::*;
  logic lockedBit;
  assign lockedBit = (opReq.sector < 4'h6) ? effectiveLock.low[opReq.sector]
                                           : effectiveLock.mid[opReq.sector[0]];
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_op; opReq.valid; endsequence
  sequence s_load; nvReadReq && nvReadValid ##1 1'b1; endsequence
  property p_or; 1'b1 |=> ($past(secondaryLock) & ~effectiveLock) == 19'h0; endproperty
  a_or: assert property (p_or) else $error("secondary lock lost");
  property p_high; effectiveLock.low[15:6] == 10'h3FF; endproperty
  a_high: assert property (p_high) else $error("unused lock bit clear");
  property p_test; s_op ##0 (opReq.erase && opReq.sector == SECTOR_TEST)
    |=> opRsp.lockedGood && !opRsp.execute; endproperty
  a_test: assert property (p_test) else $error("test erase done");
  property p_verdict; s_op |=> opRsp.done && (opRsp.execute != opRsp.lockedGood); endproperty
  a_verdict: assert property (p_verdict) else $error("bad verdict");
  property p_map; s_op ##0 (opReq.sector < 4'h8) |=> opRsp.execute != $past(lockedBit);
  endproperty
  a_map: assert property (p_map) else $error("sector map wrong");
  property p_drop; nvReadReq && nvReadValid |=> !nvReadReq; endproperty
  a_drop: assert property (p_drop) else $error("image read stuck");
  property p_loadval; s_load |=> effectiveLock.low[5:0]
    == ($past(nvImage[5:0], 2) | $past(secondaryLock.low[5:0])); endproperty
  a_loadval: assert property (p_loadval) else $error("image load wrong");
  property p_pready; apbRsp.pready |=> !apbRsp.pready; endproperty
  a_pready: assert property (p_pready) else $error("pready too long");
endmodule : flash_block_lock_chk

bind flash_block_lock flash_block_lock_chk chk_u (.clock(clock), .rstn(rstn),
  .apbReq(apbReq), .apbRsp(apbRsp), .nvReadReq(nvReadReq), .nvReadValid(nvReadValid),
  .nvImage(nvImage), .secondaryLock(secondaryLock), .interlockWrite(interlockWrite),
  .controlDone(controlDone), .hvSuspended(hvSuspended), .opReq(opReq), .opRsp(opRsp),
  .effectiveLock(effectiveLock));

/* dv/tb_flash_block_lock.sv */
// Self-checking testbench for the flash block lock register
`timescale 1ns/1ps
module tb_flash_block_lock;
  import flash_lock_pkg::*;
  logic        clock = 1'b0, rstn = 1'b0, nvValid = 1'b1, ilw = 1'b0, cdone = 1'b0;
  logic        hvs = 1'b0, nvReq, err;
  logic [63:0] img = '1;
  logic [31:0] rd;
  apb_req_t    req = '0;
  apb_rsp_t    rsp;
  op_req_t     op = '0;
  op_rsp_t     opr;
  lock_t       sec = '0, eff;
  int          num_errors = 0, compares = 0;

  flash_block_lock dut_u (.clock(clock), .rstn(rstn), .apbReq(req), .apbRsp(rsp),
    .nvReadReq(nvReq), .nvReadValid(nvValid), .nvImage(img), .secondaryLock(sec),
    .interlockWrite(ilw), .controlDone(cdone), .hvSuspended(hvs), .opReq(op),
    .opRsp(opr), .effectiveLock(eff));

  initial
  begin
    forever #25 clock = ~clock;
  end

  task automatic complete_run;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock);
    req.penable <= 1'b1;
    do
    begin
      @(posedge clock);
    end
    while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge clock);
  endtask : apb

  task automatic rc(input string s, input logic [31:0] e);
    apb(1'b0, PRIMARY_OFF, 32'h0);
    chk(s, e, rd);
  endtask : rc

  task automatic rst(input logic [63:0] im);
    rstn <= 1'b0;
    img <= im;
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
  endtask : rst

  task automatic t_enable;
    rst({32'hDEADBEEF, 32'h00020015});
    rc("loaded", 32'h0002FFD5);
    apb(1'b0, IMAGE_LO_OFF, 32'h0);
    chk("image lo", 32'h00020015, rd);
    apb(1'b0, IMAGE_HI_OFF, 32'h0);
    chk("image hi", 32'hDEADBEEF, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    apb(1'b1, PRIMARY_OFF, 32'h0);
    rc("no password", 32'h0002FFD5);
    apb(1'b1, PRIMARY_OFF, LOCK_PASSWORD);
    rc("password", 32'h8002FFD5);
    apb(1'b1, PRIMARY_OFF, 32'h0);
    rc("unlock", 32'h8000FFC0);
  endtask : t_enable

  task automatic t_block;
    ilw <= 1'b1;
    @(posedge clock);
    ilw <= 1'b0;
    apb(1'b0, STATUS_OFF, 32'h0);
    chk("status pending", 32'hA000FFC0, rd);
    apb(1'b1, PRIMARY_OFF, 32'h0013FFFF);
    rc("interlock", 32'h8000FFC0);
    cdone <= 1'b1;
    @(posedge clock);
    cdone <= 1'b0;
    hvs <= 1'b1;
    apb(1'b0, STATUS_OFF, 32'h0);
    chk("status suspend", 32'h6000FFC0, rd);
    apb(1'b1, PRIMARY_OFF, 32'h0013FFFF);
    rc("suspend", 32'h8000FFC0);
    hvs <= 1'b0;
    apb(1'b1, PRIMARY_OFF, 32'h0000FFC2);
    rc("writable", 32'h8000FFC2);
  endtask : t_block

  task automatic t_ops;
    logic [18:0] e;
    logic        x;
    int          i;
    sec <= '{1'b0, 2'b10, 16'h0001};
    e = 19'h2FFC3;
    repeat (2) @(posedge clock);
    for (i = 0; i < 18; i++)
    begin
      op <= '{1'b1, i[0], i[4:1]};
      @(posedge clock);
      op <= '0;
      @(posedge clock);
      x = i[4:1] < 6 ? e[i[4:1]] : i[4:1] < 8 ? e[i[4:1] + 10] : e[18];
      x = x | (i == 17);
      chk("op", {29'h0, 1'b1, ~x, x}, {29'h0, opr});
    end
    op <= '{1'b1, 1'b0, 4'hF};
    @(posedge clock);
    op <= '0;
    @(posedge clock);
    chk("op none", 32'h5, {29'h0, opr});
  endtask : t_ops

  initial
  begin
    t_enable;
    t_block;
    t_ops;
    rst('1);
    rc("erased", 32'h0013FFFF);
    complete_run;
  end

  initial
  begin
    #1000000;
    num_errors++;
    complete_run;
  end
endmodule : tb_flash_block_lock
